// ### acs_pkg.sv
package acs_pkg;

  // bus geometry
  localparam int ACS_ADDR_W = 8;
  localparam int ACS_DATA_W = 32;

  // register byte offsets
  localparam logic [ACS_ADDR_W-1:0] OFF_TRIG  = 8'h00;
  localparam logic [ACS_ADDR_W-1:0] OFF_STAT  = 8'h04;
  localparam logic [ACS_ADDR_W-1:0] OFF_PRE   = 8'h08;
  localparam logic [ACS_ADDR_W-1:0] OFF_CTRL  = 8'h0C;
  localparam logic [ACS_ADDR_W-1:0] OFF_ACQ   = 8'h10;
  localparam logic [ACS_ADDR_W-1:0] OFF_RES0  = 8'h14;
  localparam logic [ACS_ADDR_W-1:0] OFF_RES1  = 8'h18;
  localparam logic [ACS_ADDR_W-1:0] OFF_RES   = 8'h1C;
  localparam logic [ACS_ADDR_W-1:0] OFF_ISTAT = 8'h20;
  localparam logic [ACS_ADDR_W-1:0] OFF_IMASK = 8'h24;

  // field positions and widths
  localparam int TRIG_LSB   = 4;
  localparam int TRIG_W     = 3;
  localparam int PRE_W      = 7;
  localparam int ACQ_W      = 7;
  localparam int CH_W       = 5;
  localparam int RES_W      = 10;
  localparam int CTRL_EN    = 0;
  localparam int CTRL_GO    = 1;
  localparam int CTRL_VREF  = 2;
  localparam int CTRL_FRC   = 3;
  localparam int CTRL_CH    = 4;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_TRIG   = 1;
  localparam int IRQ_W      = 2;
  localparam int NUM_TRIG   = 5;

  // trigger source codes
  localparam logic [TRIG_W-1:0] TRG_NONE      = 3'h0;
  localparam logic [TRIG_W-1:0] TRG_CC_ONE    = 3'h1;
  localparam logic [TRIG_W-1:0] TRG_CC_TWO    = 3'h2;
  localparam logic [TRIG_W-1:0] TRG_TMR_A     = 3'h3;
  localparam logic [TRIG_W-1:0] TRG_TMR_B     = 3'h4;
  localparam logic [TRIG_W-1:0] TRG_TIMER_TWO = 3'h5;

  // stage codes as reported
  localparam logic [1:0] STG_IDLE = 2'h0;
  localparam logic [1:0] STG_PRE  = 2'h1;
  localparam logic [1:0] STG_ACQ  = 2'h2;
  localparam logic [1:0] STG_CONV = 2'h3;

  // one instruction cycle is four oscillator periods
  localparam int                   TCY_DIV   = 4;
  localparam int                   TCY_W     = 2;
  localparam logic [TCY_W-1:0]     TCY_LAST  = TCY_W'(TCY_DIV - 1);

  // reset values
  localparam logic [TRIG_W-1:0] RST_TRIG = 3'h0;
  localparam logic [PRE_W-1:0]  RST_PRE  = 7'h00;
  localparam logic [ACQ_W-1:0]  RST_ACQ  = 7'h00;
  localparam logic [CH_W-1:0]   RST_CH   = 5'h00;
  localparam logic [IRQ_W-1:0]  RST_IRQ  = 2'h0;
  localparam logic [RES_W-1:0]  RST_RES  = 10'h000;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_ACQ, ST_CONV} acs_state_e;

  // controls toward the analog front end
  typedef struct packed {
    logic             precharge;
    logic             prech_pol;
    logic             sample;
    logic             convert;
    logic             vref_ext;
    logic [CH_W-1:0]  channel;
    logic [RES_W-1:0] dac_code;
  } acs_ana_s;

endpackage

// ### acs_edge.sv
`timescale 1ns/10ps
module acs_edge
  import acs_pkg::*;
#(
  parameter int N = NUM_TRIG
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] sig,
  output logic      [N-1:0] rise
);

  logic [N-1:0] prev;

  // one previous-value flop and a rising-edge term per source
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_edge
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          prev[i] <= 1'b0;
        end else begin
          prev[i] <= sig[i];
        end
      end
      assign rise[i] = sig[i] & ~prev[i]; // edge only, a held level fires once
    end
  endgenerate

endmodule // acs_edge

// ### acs_sar.sv
`timescale 1ns/10ps
module acs_sar
  import acs_pkg::*;
#(
  parameter int W = RES_W
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic         step,
  input  wire logic         comp_above,
  output logic              busy,
  output logic              done,
  output logic      [W-1:0] code,
  output logic      [W-1:0] result
);

  logic [W-1:0] mask;
  logic [W-1:0] kept;

  // drop the trial bit when the input sits below the trial level
  assign kept = comp_above ? code : (code & ~mask);

  // one bit decided per step, msb first
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy   <= 1'b0;
      done   <= 1'b0;
      mask   <= '0;
      code   <= '0;
      result <= '0;
    end else if (start) begin
      busy <= 1'b1;
      done <= 1'b0;
      mask <= {1'b1, {(W-1){1'b0}}};
      code <= {1'b1, {(W-1){1'b0}}};
    end else if (busy && step) begin
      if (mask[0]) begin
        result <= kept; // successive approximation result
        busy   <= 1'b0;
        done   <= 1'b1;
        code   <= kept;
      end else begin
        code <= kept | (mask >> 1);
        mask <= mask >> 1;
        done <= 1'b0;
      end
    end else begin
      done <= 1'b0;
    end
  end

endmodule // acs_sar

// ### acs_top.sv
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
// Behaviour
// - ten-bit SAR result stored in result pair
// - channel mux feeds one sample-and-hold stage
// - completion interrupt, usable as wake request
// - software picks internal or external reference
// - conversions start on the go bit or on a trigger rising edge only
// - selected trigger also sets its peripheral flag
// - buffer bit high while filling second pair
// - stage field reports idle, precharge, acquire, convert
// - precharge lasts field value ticks of the selected timing base
// - zero precharge field skips the precharge phase
// - dedicated oscillator also times precharge and acquisition
module acs_top
  import acs_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // axi4-lite slave
  input  wire logic [ACS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [ACS_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ACS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [ACS_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // trigger sources and their peripheral flag set pulses
  input  wire logic [NUM_TRIG-1:0]   trig_src,
  output logic      [NUM_TRIG-1:0]   periph_flag_set,
  // dedicated conversion oscillator tick
  input  wire logic                  frc_tick,
  // analog front end
  input  wire logic                  comp_above,
  output acs_ana_s                   ana,
  output logic                       irq
);

  // write channel state
  logic                  aw_got;
  logic                  w_got;
  logic [ACS_ADDR_W-1:0] aw_addr;
  logic [ACS_DATA_W-1:0] w_data;
  logic [3:0]            w_strb;
  logic                  wr_fire;
  logic                  wr_ok;
  logic                  rd_ok;
  logic [ACS_DATA_W-1:0] rd_val;
  logic [ACS_DATA_W-1:0] wr_val;
  logic [ACS_DATA_W-1:0] wr_old;

  // software registers
  logic [TRIG_W-1:0] trigger_source_sel;
  logic [PRE_W-1:0]  precharge_cycles;
  logic [ACQ_W-1:0]  acq_cycles;
  logic              conv_enable;
  logic              vref_ext;
  logic              frc_sel;
  logic [CH_W-1:0]   channel;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  logic [RES_W-1:0]  first_result;
  logic [RES_W-1:0]  second_result;
  logic [RES_W-1:0]  result;

  // sequencer
  acs_state_e        state;
  logic              result_buffer_indicator;
  logic [1:0]        sequence_stage;
  logic [ACQ_W-1:0]  cnt;
  logic [TCY_W-1:0]  tcy_div;
  logic              tick;
  logic              pre_last;
  logic              acq_last;
  logic              sw_go;
  logic              auto_start;
  logic              start;
  logic              sar_start;
  logic              sar_busy;
  logic              sar_done;
  logic [RES_W-1:0]  sar_code;
  logic [RES_W-1:0]  sar_result;
  logic              seq_done;
  logic [NUM_TRIG-1:0] trig_rise;
  logic [NUM_TRIG-1:0] sel_onehot;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;

  // byte-lane merge of a write into the old word
  function automatic logic [ACS_DATA_W-1:0] merge(input logic [ACS_DATA_W-1:0] old_w,
                                                  input logic [ACS_DATA_W-1:0] new_w,
                                                  input logic [3:0]            strb);
    logic [ACS_DATA_W-1:0] m;
    m = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return m;
  endfunction

  // write address and data are taken independently, response after both
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign wr_fire       = aw_got && w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // write channel holding flops and response
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // current contents of the addressed word, for byte merging
  always_comb begin
    wr_old = '0;
    wr_ok  = 1'b1;
    if (aw_addr == OFF_TRIG) begin
      wr_old[TRIG_LSB +: TRIG_W] = trigger_source_sel;
    end else if (aw_addr == OFF_STAT) begin
      wr_old = '0;
    end else if (aw_addr == OFF_PRE) begin
      wr_old[PRE_W-1:0] = precharge_cycles;
    end else if (aw_addr == OFF_CTRL) begin
      wr_old[CTRL_EN]          = conv_enable;
      wr_old[CTRL_VREF]        = vref_ext;
      wr_old[CTRL_FRC]         = frc_sel;
      wr_old[CTRL_CH +: CH_W]  = channel;
    end else if (aw_addr == OFF_ACQ) begin
      wr_old[ACQ_W-1:0] = acq_cycles;
    end else if (aw_addr == OFF_ISTAT) begin
      wr_old = '0;
    end else if (aw_addr == OFF_IMASK) begin
      wr_old[IRQ_W-1:0] = irq_mask;
    end else if (aw_addr == OFF_RES0 || aw_addr == OFF_RES1 || aw_addr == OFF_RES) begin
      wr_old = '0;
    end else begin
      wr_ok = 1'b0;
    end
  end

  assign wr_val = merge(wr_old, w_data, w_strb);

  // configuration registers; only implemented bits are stored
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trigger_source_sel <= RST_TRIG;
      precharge_cycles   <= RST_PRE;
      acq_cycles         <= RST_ACQ;
      conv_enable        <= 1'b0;
      vref_ext           <= 1'b0;
      frc_sel            <= 1'b0;
      channel            <= RST_CH;
      irq_mask           <= RST_IRQ;
    end else if (wr_fire) begin
      if (aw_addr == OFF_TRIG) begin
        trigger_source_sel <= wr_val[TRIG_LSB +: TRIG_W];
      end else if (aw_addr == OFF_PRE) begin
        precharge_cycles <= wr_val[PRE_W-1:0];
      end else if (aw_addr == OFF_CTRL) begin
        conv_enable <= wr_val[CTRL_EN];
        vref_ext    <= wr_val[CTRL_VREF]; // reference source choice
        frc_sel     <= wr_val[CTRL_FRC];
        channel     <= wr_val[CTRL_CH +: CH_W];
      end else if (aw_addr == OFF_ACQ) begin
        acq_cycles <= wr_val[ACQ_W-1:0];
      end else if (aw_addr == OFF_IMASK) begin
        irq_mask <= wr_val[IRQ_W-1:0];
      end
    end
  end

  // go request from a control write
  assign sw_go = wr_fire && (aw_addr == OFF_CTRL) && wr_val[CTRL_GO];

  // read mux; status register packs buffer bit and stage
  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b1;
    if (s_axi_araddr == OFF_TRIG) begin
      rd_val[TRIG_LSB +: TRIG_W] = trigger_source_sel;
    end else if (s_axi_araddr == OFF_STAT) begin
      rd_val[2:0] = {result_buffer_indicator, sequence_stage};
    end else if (s_axi_araddr == OFF_PRE) begin
      rd_val[PRE_W-1:0] = precharge_cycles;
    end else if (s_axi_araddr == OFF_CTRL) begin
      rd_val[CTRL_EN]         = conv_enable;
      rd_val[CTRL_GO]         = (state != ST_IDLE);
      rd_val[CTRL_VREF]       = vref_ext;
      rd_val[CTRL_FRC]        = frc_sel;
      rd_val[CTRL_CH +: CH_W] = channel;
    end else if (s_axi_araddr == OFF_ACQ) begin
      rd_val[ACQ_W-1:0] = acq_cycles;
    end else if (s_axi_araddr == OFF_RES0) begin
      rd_val[RES_W-1:0] = first_result;
    end else if (s_axi_araddr == OFF_RES1) begin
      rd_val[RES_W-1:0] = second_result;
    end else if (s_axi_araddr == OFF_RES) begin
      rd_val[RES_W-1:0] = result;
    end else if (s_axi_araddr == OFF_ISTAT) begin
      rd_val[IRQ_W-1:0] = irq_status;
    end else if (s_axi_araddr == OFF_IMASK) begin
      rd_val[IRQ_W-1:0] = irq_mask;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read data channel
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // rising edge detection on every trigger input
  acs_edge #(
    .N (NUM_TRIG)
  ) u_edge (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sig      (trig_src),
    .rise     (trig_rise)
  );

  // trigger code to source; reserved codes select nothing
  always_comb begin
    sel_onehot = '0;
    case (trigger_source_sel)
      TRG_CC_ONE:    sel_onehot[0] = 1'b1;
      TRG_CC_TWO:    sel_onehot[1] = 1'b1;
      TRG_TMR_A:     sel_onehot[2] = 1'b1;
      TRG_TMR_B:     sel_onehot[3] = 1'b1;
      TRG_TIMER_TWO: sel_onehot[4] = 1'b1;
      default:       sel_onehot    = '0;
    endcase
  end

  assign periph_flag_set = trig_rise & sel_onehot; // flag set regardless of start
  assign auto_start      = |periph_flag_set;
  assign start           = conv_enable && (state == ST_IDLE) && (sw_go || auto_start);

  // instruction-cycle divider, free running
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tcy_div <= '0;
    end else begin
      tcy_div <= tcy_div + 1'b1;
    end
  end

  // timing base: instruction cycle or dedicated oscillator
  assign tick     = frc_sel ? frc_tick : (tcy_div == TCY_LAST);
  assign pre_last = tick && ((cnt + 1'b1) == precharge_cycles);
  assign acq_last = tick && ((cnt + 1'b1) >= acq_cycles);
  assign sar_start = (state == ST_ACQ) && acq_last;
  assign seq_done  = (state == ST_CONV) && sar_done && result_buffer_indicator;

  // sequence: precharge, acquisition, conversion, twice per trigger
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state                   <= ST_IDLE;
      cnt                     <= '0;
      result_buffer_indicator <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt                     <= '0;
          result_buffer_indicator <= 1'b0;
          if (start) begin
            state <= (precharge_cycles == '0) ? ST_ACQ : ST_PRE;
          end
        end
        ST_PRE: begin
          if (pre_last) begin
            state <= ST_ACQ;
            cnt   <= '0;
          end else if (tick) begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_ACQ: begin
          if (acq_last) begin
            state <= ST_CONV;
            cnt   <= '0;
          end else if (tick) begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_CONV: begin
          if (sar_done) begin
            cnt <= '0;
            if (result_buffer_indicator) begin
              state                   <= ST_IDLE;
              result_buffer_indicator <= 1'b0;
            end else begin
              result_buffer_indicator <= 1'b1; // second pair next
              state <= (precharge_cycles == '0) ? ST_ACQ : ST_PRE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // stage code from the state
  always_comb begin
    case (state)
      ST_PRE:  sequence_stage = STG_PRE;
      ST_ACQ:  sequence_stage = STG_ACQ;
      ST_CONV: sequence_stage = STG_CONV;
      default: sequence_stage = STG_IDLE;
    endcase
  end

  // successive approximation engine, one bit per tick
  acs_sar #(
    .W (RES_W)
  ) u_sar (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .start      (sar_start),
    .step       (tick),
    .comp_above (comp_above),
    .busy       (sar_busy),
    .done       (sar_done),
    .code       (sar_code),
    .result     (sar_result)
  );

  // result pairs and latest result
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      first_result  <= RST_RES;
      second_result <= RST_RES;
      result        <= RST_RES;
    end else if ((state == ST_CONV) && sar_done) begin
      result <= sar_result;
      if (result_buffer_indicator) begin
        second_result <= sar_result;
      end else begin
        first_result <= sar_result;
      end
    end
  end

  // sticky events; a set in the clearing cycle wins
  assign irq_set[IRQ_DONE] = seq_done;
  assign irq_set[IRQ_TRIG] = auto_start;
  assign irq_clr = (wr_fire && aw_addr == OFF_ISTAT) ? wr_val[IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_status <= RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  // level interrupt, also the wake request
  assign irq = |(irq_status & irq_mask);

  // analog front end controls; one channel to the shared hold stage
  assign ana.precharge = (state == ST_PRE);
  assign ana.prech_pol = result_buffer_indicator;
  assign ana.sample    = (state == ST_ACQ);
  assign ana.convert   = sar_busy;
  assign ana.vref_ext  = vref_ext;
  assign ana.channel   = channel;
  assign ana.dac_code  = sar_code;

endmodule // acs_top

// ### acs_top_sva.sv
`timescale 1ns/10ps
module acs_top_sva
  import acs_pkg::*;
(
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic [NUM_TRIG-1:0] trig_src,
  input wire logic [NUM_TRIG-1:0] periph_flag_set,
  input wire acs_ana_s            ana
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // both write channels taken in one cycle
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // conversion phase begins
  sequence s_conv_start;
    $rose(ana.convert);
  endsequence

  AST_WR_RESP: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  AST_FLAG_ONE: assert property ($onehot0(periph_flag_set))
    else $error("more than one source flag");
  AST_FLAG_SRC: assert property (|periph_flag_set |-> |(periph_flag_set & trig_src))
    else $error("flag without its source high");
  AST_FLAG_PULSE: assert property (|periph_flag_set |=> !(|periph_flag_set))
    else $error("flag held on a level");
  AST_FLAG_EDGE: assert property ((periph_flag_set & $past(trig_src)) == '0)
    else $error("flag from a source already high");
  AST_ANA_EXCL: assert property ($onehot0({ana.precharge, ana.sample, ana.convert}))
    else $error("two phases at once");
  AST_CONV_SAMPLE: assert property (s_conv_start |-> $past(ana.sample))
    else $error("conversion not after acquisition");
  AST_CONV_HOLD: assert property (s_conv_start |-> ana.convert[*8])
    else $error("conversion too short");
endmodule // acs_top_sva

bind acs_top acs_top_sva i_acs_top_sva (.core_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .trig_src, .periph_flag_set, .ana);

// ### acs_afe_model.sv
`timescale 1ns/10ps
module acs_afe_model
  import acs_pkg::*;
(
  input  wire logic             core_clk,
  input  wire acs_ana_s         ana,
  input  wire logic [RES_W-1:0] level,
  output logic                  comp_above
);
  logic [RES_W-1:0] held;
  logic             tgl = 1'h0;
  // hold tracks the input while sampling; noise outside conversion
  always_ff @(posedge core_clk) begin
    if (ana.sample) held <= level;
    tgl <= ~tgl;
  end
  // comparator against the trial code
  assign comp_above = ana.convert ? (held >= ana.dac_code) : tgl;
endmodule // acs_afe_model

// ### tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((e) !== (a)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb_top
  import acs_pkg::*;
;
  logic                  core_clk = 1'h0;
  logic                  rst_n = 1'h0;
  logic                  awv = 1'h0, wv = 1'h0, arv = 1'h0, frc_tick = 1'h0, frc_on = 1'h0;
  logic                  awr, wr, bv, arr, rv, irq, comp;
  logic [ACS_ADDR_W-1:0] awa = 8'h0, ara = 8'h0;
  logic [ACS_DATA_W-1:0] wd = 32'h0, rd;
  logic [1:0]            bresp, rresp, eb;
  logic [NUM_TRIG-1:0]   trig = 5'h0, flags, facc;
  logic [RES_W-1:0]      level = 10'h0;
  logic [15:0]           rnd = 16'h0015;
  logic [33:0]           er;
  acs_ana_s              ana;
  int                    err_count = 0, comparisons = 0, pcnt = 0, fcnt = 0, div = 0;
  logic [1:0]            exp_b[$];
  logic [33:0]           exp_r[$];

  acs_top i_acs_top (.core_clk, .rst_n, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'h1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'h1), .trig_src(trig),
    .periph_flag_set(flags), .frc_tick, .comp_above(comp), .ana, .irq);
  acs_afe_model i_acs_afe_model (.core_clk, .ana, .level, .comp_above(comp));

  // clock
  initial forever #4 core_clk = ~core_clk;

  // responses checked against oldest note
  always @(posedge core_clk) begin
    if (bv) begin eb = exp_b.pop_front(); `CHK("bresp", eb, bresp) end
    if (rv) begin er = exp_r.pop_front(); `CHK("rdata", er, {rresp, rd}) end
  end

  // phase, flag and oscillator bookkeeping
  always @(posedge core_clk) begin
    pcnt <= pcnt + int'(ana.precharge);
    div <= (div == 6) ? 0 : div + 1;
    frc_tick <= frc_on && (div == 6);
    facc <= (trig == 5'h0) ? 5'h0 : facc | flags;
    fcnt <= (trig == 5'h0) ? 0 : fcnt + int'(|flags);
  end

  task automatic final_report;
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic timeout;
    err_count++;
    final_report;
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // one bus write (w=1) or read, expected answer noted first
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    int n;
    if (w) begin
      exp_b.push_back(r);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
    end else begin
      exp_r.push_back({r, d});
      ara <= a;
      arv <= 1'h1;
    end
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk);
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
      if (arr) arv <= 1'h0;
      if (w ? bv : rv) break;
    end
    if (n == 200) timeout;
  endtask

  // wait for a front-end phase or irq to reach a level
  task automatic wt(input int k, input logic v);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge core_clk);
      if ((k == 0 ? ana.convert : k == 1 ? ana.sample : k == 2 ? ana.precharge : irq) === v) break;
    end
    if (n == 3000) timeout;
  endtask

  // one sequence started by go (t=0) or by the timer two edge (t=1)
  task automatic run(input logic [6:0] p, input logic f, input logic t);
    int b;
    int tk;
    logic [4:0] ch;
    rnd = lfsr(rnd);
    level <= rnd[9:0];
    ch = rnd[14:10];
    tk = f ? 7 : 4;
    frc_on <= f;
    bus(1, OFF_PRE, {25'h0, p}, RESP_OKAY);
    bus(1, OFF_ACQ, 32'h14, RESP_OKAY);
    bus(1, OFF_ISTAT, 32'h3, RESP_OKAY);
    bus(1, OFF_IMASK, 32'h1, RESP_OKAY);
    bus(1, OFF_TRIG, {25'h0, TRG_TIMER_TWO, 4'h0}, RESP_OKAY);
    bus(1, OFF_CTRL, {23'h0, ch, f, f, 2'h1}, RESP_OKAY);
    `CHK("vref", f, ana.vref_ext)
    `CHK("chan", ch, ana.channel)
    b = pcnt;
    if (t) trig <= 5'h10;
    else bus(1, OFF_CTRL, {23'h0, ch, f, f, 2'h3}, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    bus(0, OFF_STAT, p ? 32'h1 : 32'h2, RESP_OKAY);
    wt(0, 1'h1);
    bus(0, OFF_STAT, 32'h3, RESP_OKAY);
    wt(0, 1'h0);
    wt(p ? 2 : 1, 1'h1);
    `CHK("pol", 1'h1, ana.prech_pol)
    bus(0, OFF_STAT, p ? 32'h5 : 32'h6, RESP_OKAY);
    wt(3, 1'h1);
    trig <= 5'h0;
    bus(0, OFF_STAT, 32'h0, RESP_OKAY);
    bus(0, OFF_RES0, {22'h0, level}, RESP_OKAY);
    bus(0, OFF_RES1, {22'h0, level}, RESP_OKAY);
    bus(0, OFF_RES, {22'h0, level}, RESP_OKAY);
    bus(0, OFF_ISTAT, {30'h0, t, 1'h1}, RESP_OKAY);
    b = pcnt - b;
    `CHK("pre_len", 1'h1, p == 0 ? b == 0 : (b > 2 * (int'(p) - 1) * tk && b <= 2 * int'(p) * tk))
    bus(1, OFF_IMASK, 32'h0, RESP_OKAY);
    `CHK("irq_masked", 1'h0, irq)
    bus(1, OFF_IMASK, 32'h1, RESP_OKAY);
    `CHK("irq_on", 1'h1, irq)
    bus(1, OFF_ISTAT, 32'h3, RESP_OKAY);
    `CHK("irq_clr", 1'h0, irq)
  endtask

  // main sequence
  initial begin
    logic [4:0] e;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    bus(0, OFF_TRIG, 32'h0, RESP_OKAY);
    bus(0, OFF_PRE, 32'h0, RESP_OKAY);
    bus(1, OFF_TRIG, 32'hFFFFFFFF, RESP_OKAY);
    bus(1, OFF_STAT, 32'hFFFFFFFF, RESP_OKAY);
    bus(1, OFF_PRE, 32'hFFFFFFFF, RESP_OKAY);
    bus(0, OFF_TRIG, 32'h70, RESP_OKAY);
    bus(0, OFF_STAT, 32'h0, RESP_OKAY);
    bus(0, OFF_PRE, 32'h7F, RESP_OKAY);
    bus(1, 8'h30, 32'h0, RESP_SLVERR);
    bus(0, 8'h30, 32'h0, RESP_SLVERR);
    for (int c = 0; c < 8; c++) begin
      e = (c >= 1 && c <= 5) ? 5'(1 << (c - 1)) : 5'h0;
      bus(1, OFF_TRIG, {25'h0, 3'(c), 4'h0}, RESP_OKAY);
      trig <= 5'h1F;
      repeat (10) @(posedge core_clk);
      `CHK("flags", e, facc)
      `CHK("edges", int'(e != 5'h0), fcnt)
      trig <= 5'h0;
      repeat (2) @(posedge core_clk);
    end
    run(7'h14, 1'h0, 1'h0);
    run(7'h00, 1'h1, 1'h0);
    run(7'h03, 1'h1, 1'h1);
    final_report;
  end
endmodule // tb_top
